// >>> hw/sew_slave.sv
`timescale 1ns/1ns
module sew_slave #(
	parameter int unsigned WRITE_CLKS = sew_pkg::WRITE_CYCLE_CLKS,
	parameter int unsigned POR_CLKS = sew_pkg::POR_DELAY_CLKS
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic scl,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	output logic por_reset_n,
	output logic write_busy
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		sew_pkg::sew_state_t state;
		logic scl_q;
		logic sda_q;
		logic [3:0] bitcnt;
		logic ack_slot;
		logic [7:0] shift;
		logic is_read;
		logic is_reg;
		logic addr_msb;
		logic [8:0] addr;
		logic [8:0] wr_addr;
		logic [127:0] page_buf;
		logic [15:0] page_mask;
		logic got_byte;
		logic busy;
		logic [31:0] wcnt;
		logic [4:0] commit_idx;
		logic [4:0] page_base;
		logic permit;
		logic reg_permit;
		logic [7:0] control_nv;
		logic [7:0] fault_cause;
		logic [31:0] por_cnt;
		logic por_n;
		logic sda_oe_n;
	} sew_regs_t;

	sew_regs_t r_reg;
	sew_regs_t r_next;

	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic dev_match;
	logic store_ok;
	logic [7:0] rd_byte;
	logic [7:0] mem_rdata;
	logic [7:0] stop_data;
	logic mem_we;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Register space read mux
	function automatic logic [7:0] reg_read(input logic [8:0] a, input sew_regs_t r);
		logic [7:0] v;
		v = 8'h00;
		if (a == sew_pkg::CTRL_ADDR) begin
			v = r.control_nv;
			v[sew_pkg::PERMIT_BIT] = r.permit;
			v[sew_pkg::REG_PERMIT_BIT] = r.reg_permit;
		end else if (a == sew_pkg::FAULT_ADDR) begin
			v = r.fault_cause;
		end
		return v;
	endfunction : reg_read

	// One byte out of the page buffer
	function automatic logic [7:0] buf_byte(input logic [127:0] b, input logic [3:0] idx);
		return b[{idx, 3'h0} +: 8];
	endfunction : buf_byte

	// ****************************************************************
	// Line synchronisers and the array
	// ****************************************************************
	sew_sync u_scl_sync (
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.d(scl),
		.q(scl_s)
	);

	sew_sync u_sda_sync (
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.d(sda_i),
		.q(sda_s)
	);

	// Write port drains the page buffer during the timed write
	assign mem_we = clk_en && r_reg.busy && !r_reg.commit_idx[4] && r_reg.page_mask[r_reg.commit_idx[3:0]];

	sew_mem u_mem (
		.clk(clk),
		.we(mem_we),
		.waddr({r_reg.page_base, r_reg.commit_idx[3:0]}),
		.wdata(buf_byte(r_reg.page_buf, r_reg.commit_idx[3:0])),
		.raddr(r_reg.addr),
		.rdata(mem_rdata)
	);

	// ****************************************************************
	// Bus event decode
	// ****************************************************************
	// Edges and conditions from registered line copies
	always_comb begin
		scl_rise = !r_reg.scl_q && scl_s;
		scl_fall = r_reg.scl_q && !scl_s;
		start_det = r_reg.scl_q && scl_s && r_reg.sda_q && !sda_s;
		stop_det = r_reg.scl_q && scl_s && !r_reg.sda_q && sda_s;
		dev_match = (r_reg.shift[7:4] == sew_pkg::TYPE_ARRAY || r_reg.shift[7:4] == sew_pkg::TYPE_REGS)
			&& r_reg.shift[3:2] == sew_pkg::SELECT_BITS && !r_reg.busy;
		rd_byte = r_reg.is_reg ? reg_read(r_reg.addr, r_reg) : mem_rdata;
		stop_data = buf_byte(r_reg.page_buf, r_reg.wr_addr[3:0]);
	end

	// Whether a received data byte is taken
	always_comb begin
		if (r_reg.is_reg) begin
			store_ok = !r_reg.got_byte && (r_reg.addr == sew_pkg::FAULT_ADDR
				|| (r_reg.addr == sew_pkg::CTRL_ADDR && (r_reg.permit
				|| r_reg.shift == sew_pkg::CMD_SET_PERMIT || r_reg.shift == sew_pkg::CMD_CLR_PERMIT)));
		end else begin
			store_ok = r_reg.permit && !(r_reg.control_nv[sew_pkg::PROTECT_BIT] && r_reg.addr[8]);
		end
	end

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb begin
		r_next = r_reg;
		r_next.scl_q = scl_s;
		r_next.sda_q = sda_s;
		// Power-on reset output timer
		if (!r_reg.por_n) begin
			if (r_reg.por_cnt >= POR_CLKS - 1) begin
				r_next.por_n = 1'b1;
			end else begin
				r_next.por_cnt = r_reg.por_cnt + 32'h1;
			end
		end
		// Timed write: commit the page then wait out the cycle
		if (r_reg.busy) begin
			if (!r_reg.commit_idx[4]) begin
				r_next.commit_idx = r_reg.commit_idx + 5'h01;
			end
			if (r_reg.wcnt >= WRITE_CLKS - 1) begin
				r_next.busy = 1'b0;
			end else begin
				r_next.wcnt = r_reg.wcnt + 32'h1;
			end
		end
		if (start_det) begin
			r_next.state = sew_pkg::ST_DEVADDR;
			r_next.bitcnt = 4'h0;
			r_next.ack_slot = 1'b0;
			r_next.sda_oe_n = 1'b1;
			r_next.got_byte = 1'b0;
		end else if (stop_det) begin
			// Launch only after a whole acknowledged data byte; the stop's own scl rise counts as one bit
			if (r_reg.state == sew_pkg::ST_WDATA && r_reg.got_byte && r_reg.bitcnt == 4'h1
				&& !r_reg.ack_slot) begin
				if (!r_reg.is_reg) begin
					r_next.busy = 1'b1;
					r_next.wcnt = 32'h0;
					r_next.commit_idx = 5'h00;
					r_next.page_base = r_reg.wr_addr[8:4];
				end else if (r_reg.wr_addr == sew_pkg::FAULT_ADDR) begin
					r_next.fault_cause = stop_data;
				end else if (r_reg.reg_permit) begin
					if (!stop_data[sew_pkg::REG_PERMIT_BIT]) begin
						r_next.control_nv = stop_data & sew_pkg::CTRL_NV_MASK;
						r_next.reg_permit = 1'b0;
						r_next.busy = 1'b1;
						r_next.wcnt = 32'h0;
						r_next.commit_idx = sew_pkg::PAGE_DONE;
					end
				end else if (stop_data == sew_pkg::CMD_SET_REG_PERMIT && r_reg.permit) begin
					r_next.reg_permit = 1'b1;
				end else if (stop_data == sew_pkg::CMD_SET_PERMIT || stop_data == sew_pkg::CMD_CLR_PERMIT) begin
					r_next.permit = stop_data[sew_pkg::PERMIT_BIT];
				end
			end
			r_next.state = sew_pkg::ST_IDLE;
			r_next.sda_oe_n = 1'b1;
			r_next.ack_slot = 1'b0;
		end else if (scl_rise) begin
			case (r_reg.state)
				sew_pkg::ST_DEVADDR, sew_pkg::ST_WORDADDR, sew_pkg::ST_WDATA: begin
					if (!r_reg.ack_slot && r_reg.bitcnt < sew_pkg::BITS_PER_BYTE) begin
						r_next.shift = {r_reg.shift[6:0], sda_s};
						r_next.bitcnt = r_reg.bitcnt + 4'h1;
					end
				end
				sew_pkg::ST_RDATA: begin
					if (r_reg.bitcnt == sew_pkg::ACK_SLOT && sda_s) begin
						r_next.state = sew_pkg::ST_IGNORE;
					end
				end
				default: begin
					r_next.state = r_reg.state;
				end
			endcase
		end else if (scl_fall) begin
			if (r_reg.ack_slot) begin
				// End of the ninth clock: release, or start a read byte
				r_next.ack_slot = 1'b0;
				r_next.sda_oe_n = 1'b1;
				if (r_reg.state == sew_pkg::ST_RDATA) begin
					r_next.sda_oe_n = rd_byte[7];
					r_next.shift = {rd_byte[6:0], 1'b0};
					r_next.bitcnt = 4'h1;
					r_next.addr = r_reg.addr + 9'h001;
				end
			end else begin
				case (r_reg.state)
					sew_pkg::ST_DEVADDR: begin
						if (r_reg.bitcnt == sew_pkg::BITS_PER_BYTE) begin
							r_next.bitcnt = 4'h0;
							if (dev_match) begin
								r_next.ack_slot = 1'b1;
								r_next.sda_oe_n = 1'b0;
								r_next.is_reg = r_reg.shift[4];
								r_next.addr_msb = r_reg.shift[1];
								r_next.is_read = r_reg.shift[0];
								r_next.state = r_reg.shift[0] ? sew_pkg::ST_RDATA : sew_pkg::ST_WORDADDR;
							end else begin
								r_next.state = sew_pkg::ST_IGNORE;
							end
						end
					end
					sew_pkg::ST_WORDADDR: begin
						if (r_reg.bitcnt == sew_pkg::BITS_PER_BYTE) begin
							r_next.bitcnt = 4'h0;
							r_next.addr = {r_reg.addr_msb, r_reg.shift};
							r_next.page_mask = 16'h0000;
							r_next.ack_slot = 1'b1;
							r_next.sda_oe_n = 1'b0;
							r_next.state = sew_pkg::ST_WDATA;
						end
					end
					sew_pkg::ST_WDATA: begin
						if (r_reg.bitcnt == sew_pkg::BITS_PER_BYTE) begin
							r_next.bitcnt = 4'h0;
							if (store_ok) begin
								r_next.page_buf[{r_reg.addr[3:0], 3'h0} +: 8] = r_reg.shift;
								r_next.page_mask[r_reg.addr[3:0]] = 1'b1;
								if (!r_reg.got_byte) begin
									r_next.wr_addr = r_reg.addr;
								end
								r_next.got_byte = 1'b1;
								r_next.addr = {r_reg.addr[8:4], r_reg.addr[3:0] + 4'h1};
								r_next.ack_slot = 1'b1;
								r_next.sda_oe_n = 1'b0;
							end else begin
								r_next.got_byte = 1'b0;
								r_next.state = sew_pkg::ST_IGNORE;
							end
						end
					end
					sew_pkg::ST_RDATA: begin
						if (r_reg.bitcnt < sew_pkg::BITS_PER_BYTE) begin
							r_next.sda_oe_n = r_reg.shift[7];
							r_next.shift = {r_reg.shift[6:0], 1'b0};
							r_next.bitcnt = r_reg.bitcnt + 4'h1;
						end else if (r_reg.bitcnt == sew_pkg::BITS_PER_BYTE) begin
							r_next.sda_oe_n = 1'b1;
							r_next.bitcnt = sew_pkg::ACK_SLOT;
						end else begin
							// Master acknowledged: next byte, counter wraps at top
							r_next.sda_oe_n = rd_byte[7];
							r_next.shift = {rd_byte[6:0], 1'b0};
							r_next.bitcnt = 4'h1;
							r_next.addr = r_reg.addr + 9'h001;
						end
					end
					default: begin
						r_next.sda_oe_n = 1'b1;
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	// Power-up state: standby, line released, permit clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r_reg <= '0;
			r_reg.state <= sew_pkg::ST_IDLE;
			r_reg.scl_q <= 1'b1;
			r_reg.sda_q <= 1'b1;
			r_reg.sda_oe_n <= 1'b1;
			r_reg.addr <= sew_pkg::ADDR_RESET;
			r_reg.commit_idx <= sew_pkg::PAGE_DONE;
			r_reg.control_nv <= sew_pkg::CTRL_RESET & sew_pkg::CTRL_NV_MASK;
			r_reg.fault_cause <= sew_pkg::FAULT_RESET;
		end else if (clk_en) begin
			r_reg <= r_next;
		end
	end

	assign sda_o = r_reg.sda_oe_n;
	assign sda_oe_n = r_reg.sda_oe_n;
	assign por_reset_n = r_reg.por_n;
	assign write_busy = r_reg.busy;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence dev_decide_s;
		clk_en && scl_fall && !start_det && !stop_det && r_reg.state == sew_pkg::ST_DEVADDR
			&& !r_reg.ack_slot && r_reg.bitcnt == sew_pkg::BITS_PER_BYTE;
	endsequence

	sequence launch_s;
		clk_en && stop_det && r_reg.state == sew_pkg::ST_WDATA && r_reg.got_byte && !r_reg.is_reg
			&& r_reg.bitcnt == 4'h1 && !r_reg.ack_slot;
	endsequence

	addr_nack_a: assert property (dev_decide_s ##0 !dev_match |=> sda_oe_n && r_reg.state == sew_pkg::ST_IGNORE)
		else $error("mismatched slave address was acknowledged");
	busy_nack_a: assert property (dev_decide_s ##0 r_reg.busy |=> sda_oe_n)
		else $error("slave address acknowledged during timed write");
	stop_idle_a: assert property (clk_en && stop_det |=> r_reg.state == sew_pkg::ST_IDLE && sda_oe_n)
		else $error("stop did not return to standby");
	write_launch_a: assert property (launch_s |=> write_busy [*4])
		else $error("timed write not launched and held after stop");
	abort_write_a: assert property (clk_en && stop_det && r_reg.state == sew_pkg::ST_WDATA && !r_reg.busy
		&& r_reg.bitcnt != 4'h1 |=> !write_busy)
		else $error("partial data byte launched a write");
	page_wrap_a: assert property (clk_en && scl_fall && !start_det && !stop_det && r_reg.state == sew_pkg::ST_WDATA
		&& !r_reg.ack_slot && r_reg.bitcnt == sew_pkg::BITS_PER_BYTE && store_ok
		|=> r_reg.addr[8:4] == $past(r_reg.addr[8:4]) && r_reg.addr[3:0] == $past(r_reg.addr[3:0]) + 4'h1)
		else $error("page write address left its page");
	protect_nack_a: assert property (clk_en && scl_fall && !start_det && !stop_det && r_reg.state == sew_pkg::ST_WDATA
		&& !r_reg.ack_slot && r_reg.bitcnt == sew_pkg::BITS_PER_BYTE && !store_ok ##1 1'b1 [*2]
		|-> sda_oe_n)
		else $error("refused data byte was acknowledged");
	seq_read_a: assert property (clk_en && scl_fall && !start_det && !stop_det && r_reg.state == sew_pkg::ST_RDATA
		&& !r_reg.ack_slot && r_reg.bitcnt == sew_pkg::ACK_SLOT |=> r_reg.addr == $past(r_reg.addr) + 9'h001)
		else $error("read counter did not advance by one");
	por_hold_a: assert property (r_reg.por_cnt < POR_CLKS - 1 |-> !por_reset_n)
		else $error("reset output released before power-on delay");
	dummy_load_a: assert property (clk_en && stop_det && r_reg.state == sew_pkg::ST_WDATA && !r_reg.got_byte
		|=> r_reg.addr == $past(r_reg.addr) && !write_busy)
		else $error("set-address stop changed counter or wrote");
endmodule : sew_slave

// >>> common/sew_pkg.sv
// ****************************************************************
// Shared constants and types of the two-wire memory slave
// ****************************************************************
package sew_pkg;
	// Clock rate and time figures
	localparam int CLK_PERIOD_NS = 4;
	localparam int WRITE_CYCLE_MS = 5;
	localparam int WRITE_CYCLE_CLKS = WRITE_CYCLE_MS * 1000000 / CLK_PERIOD_NS;
	localparam int POR_DELAY_MS = 200;
	localparam int POR_DELAY_CLKS = POR_DELAY_MS * 1000000 / CLK_PERIOD_NS;

	// Slave address byte fields
	localparam logic [3:0] TYPE_ARRAY = 4'hA;
	localparam logic [3:0] TYPE_REGS = 4'hB;
	localparam logic [1:0] SELECT_BITS = 2'h0;

	// Address map
	localparam int MEM_DEPTH = 512;
	localparam int PAGE_BYTES = 16;
	localparam logic [8:0] CTRL_ADDR = 9'h1FF;
	localparam logic [8:0] FAULT_ADDR = 9'h0FF;
	localparam logic [8:0] ADDR_RESET = 9'h000;

	// Control settings register layout, reset values and command bytes
	localparam int PERMIT_BIT = 1;
	localparam int REG_PERMIT_BIT = 2;
	localparam int PROTECT_BIT = 4;
	localparam logic [7:0] CTRL_RESET = 8'h61;
	localparam logic [7:0] CTRL_NV_MASK = 8'hF1;
	localparam logic [7:0] FAULT_RESET = 8'h00;
	localparam logic [7:0] CMD_SET_PERMIT = 8'h02;
	localparam logic [7:0] CMD_CLR_PERMIT = 8'h00;
	localparam logic [7:0] CMD_SET_REG_PERMIT = 8'h06;

	// Bit counts within a byte frame and the page commit end index
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] ACK_SLOT = 4'h9;
	localparam logic [4:0] PAGE_DONE = 5'h10;

	// Protocol states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEVADDR,
		ST_WORDADDR,
		ST_WDATA,
		ST_RDATA,
		ST_IGNORE
	} sew_state_t;
endpackage : sew_pkg

// >>> hw/sew_sync.sv
`timescale 1ns/1ns
// ****************************************************************
// Two-flop synchroniser for a bus line
// ****************************************************************
module sew_sync (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic d,
	output logic q
);
	typedef struct packed {
		logic meta;
		logic stable;
	} sew_sync_t;

	sew_sync_t s_reg;
	sew_sync_t s_next;

	// Shift the line through both stages
	always_comb begin
		s_next.meta = d;
		s_next.stable = s_reg.meta;
	end

	// Idle bus level is high
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= 2'h3;
		end else if (clk_en) begin
			s_reg <= s_next;
		end
	end

	assign q = s_reg.stable;
endmodule : sew_sync

// >>> hw/sew_mem.sv
`timescale 1ns/1ns
// ****************************************************************
// Nonvolatile array model, one write port and one read port
// ****************************************************************
module sew_mem (
	input wire logic clk,
	input wire logic we,
	input wire logic [8:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [8:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] mem_reg [0:sew_pkg::MEM_DEPTH-1];

	// Commit one byte per enabled cycle
	always_ff @(posedge clk) begin
		if (we) begin
			mem_reg[waddr] <= wdata;
		end
	end

	// Read port follows the address counter
	assign rdata = mem_reg[raddr];
endmodule : sew_mem

// >>> tb/sew_bus_master.sv
`timescale 1ns/1ns
// ****************************************************************
// Two-wire bus master model, paced by the link clock
// ****************************************************************
module sew_bus_master (
	input wire logic link_clk,
	input wire logic sda_w,
	output logic scl,
	output logic sda_drv
);
	// Both lines idle high at time zero
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// A third of a bus clock period (scl high one tick, low two)
	task automatic tick();
		repeat (2) @(posedge link_clk);
	endtask : tick
	// Start or repeated start, scl left low
	task automatic start_c();
		sda_drv <= 1'b1;
		tick();
		scl <= 1'b1;
		tick();
		sda_drv <= 1'b0;
		tick();
		scl <= 1'b0;
		tick();
	endtask : start_c
	// Stop, only once the transmitter has let go
	task automatic stop_c();
		sda_drv <= 1'b0;
		tick();
		scl <= 1'b1;
		tick();
		sda_drv <= 1'b1;
		tick();
	endtask : stop_c
	// One clock: data set while scl low, wire sampled while scl high
	task automatic bit_io(input logic b, output logic r);
		sda_drv <= b;
		tick();
		scl <= 1'b1;
		tick();
		r = sda_w;
		scl <= 1'b0;
		tick();
	endtask : bit_io
	// First n bits MSB first; a full byte also reads the ninth clock
	task automatic wr_byte(input logic [7:0] d, input int n, output logic ack);
		logic r;
		r = 1'b1;
		for (int i = 7; i > 7 - n; i--)
			bit_io(d[i], r);
		if (n == 8)
			bit_io(1'b1, r);
		ack = ~r;
	endtask : wr_byte
	// Byte in, then own answer in the ninth clock
	task automatic rd_byte(input logic ack_in, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(~ack_in, r);
	endtask : rd_byte
endmodule : sew_bus_master

// >>> tb/tb.sv
`timescale 1ns/1ns
// ****************************************************************
// Self-checking bench of the two-wire memory slave
// ****************************************************************
module tb;
	localparam logic [3:0] TA = sew_pkg::TYPE_ARRAY;
	localparam logic [3:0] TR = sew_pkg::TYPE_REGS;
	logic clk;
	logic link_clk;
	logic reset_n;
	logic clk_en;
	logic scl;
	logic sda_drv;
	logic sda_w;
	logic sda_o;
	logic sda_oe_n;
	logic por_reset_n;
	logic write_busy;
	int bad_count;
	int total_checks;
	int seed;
	int ctr_m;
	logic [7:0] mem_m [int];
	logic [7:0] q [$];
	logic [7:0] bad_sb [4] = '{8'h90, 8'hA8, 8'hB4, 8'h5A};
	logic ack;
	logic [7:0] rd;
	logic jitter_on;
	// Wire with pull-up, low when either side pulls
	assign sda_w = sda_drv & sda_oe_n;
	sew_slave #(.WRITE_CLKS(2000), .POR_CLKS(20)) DUT (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
		.scl(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .por_reset_n(por_reset_n),
		.write_busy(write_busy));
	sew_bus_master m (.link_clk(link_clk), .sda_w(sda_w), .scl(scl), .sda_drv(sda_drv));
	// System clock, 4 ns
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Link clock, 30 ns, own phase
	initial begin
		link_clk = 1'b0;
		#7;
		forever #15 link_clk = ~link_clk;
	end
	// Clock enable, dropped about one cycle in eight once jitter is on
	always @(posedge clk) begin
		clk_en <= !jitter_on || (($random(seed) & 7) != 0);
	end
	// Compare and count
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Verdict and end of run
	task automatic summarize();
		if (bad_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize
	// Slave address byte
	function automatic logic [7:0] sb(input logic [3:0] t, input logic [8:0] a, input logic rw);
		return {t, 2'b00, a[8], rw};
	endfunction : sb
	// Start, slave byte and word address
	task automatic head(input logic [3:0] t, input logic [8:0] a);
		m.start_c();
		m.wr_byte(sb(t, a, 1'b0), 8, ack);
		check("slave ack", ack, 1'b1);
		m.wr_byte(a[7:0], 8, ack);
		check("word ack", ack, 1'b1);
	endtask : head
	// Polling refused while the timed write runs
	task automatic poll();
		int n;
		n = 0;
		ack = 1'b0;
		while (ack !== 1'b1 && n < 40) begin
			m.start_c();
			m.wr_byte(sb(TA, 9'h000, 1'b0), 8, ack);
			m.stop_c();
			if (n == 0)
				check("first poll", ack, 1'b0);
			n++;
		end
		check("poll done", ack, 1'b1);
	endtask : poll
	// Write frame of q; every data byte is sent and its ack is expected to equal ok
	task automatic wr_frame(input logic [3:0] t, input logic [8:0] a, input logic ok, input logic timed);
		head(t, a);
		foreach (q[i]) begin
			m.wr_byte(q[i], 8, ack);
			check("data ack", ack, ok);
			if (ok && t == TA)
				mem_m[{a[8:4], 4'(a[3:0] + i)}] = q[i];
		end
		m.stop_c();
		repeat (3) @(posedge clk);
		check("busy", write_busy, ok & timed);
		if (ok & timed)
			poll();
	endtask : wr_frame
	// Data bytes from the counter, last one refused, then stop
	task automatic rd_tail(input logic [3:0] t, input int n, input logic [7:0] rexp);
		for (int i = 0; i < n; i++) begin
			m.rd_byte(i < n - 1, rd);
			check("read data", rd, t == TA ? mem_m[ctr_m] : rexp);
			ctr_m = (ctr_m + 1) % 512;
		end
		m.stop_c();
		repeat (3) @(posedge clk);
		check("released", sda_oe_n, 1'b1);
	endtask : rd_tail
	// Random read: dummy write, repeated start, read
	task automatic rd_frame(input logic [3:0] t, input logic [8:0] a, input int n, input logic [7:0] rexp);
		head(t, a);
		m.start_c();
		m.wr_byte(sb(t, a, 1'b1), 8, ack);
		check("read slave ack", ack, 1'b1);
		ctr_m = a;
		rd_tail(t, n, rexp);
	endtask : rd_frame
	// Current-address read of one byte
	task automatic cur_read();
		m.start_c();
		m.wr_byte(sb(TA, 9'h000, 1'b1), 8, ack);
		check("cur slave ack", ack, 1'b1);
		rd_tail(TA, 1, 8'h00);
	endtask : cur_read
	// Main sequence
	initial begin
		seed = 91;
		bad_count = 0;
		total_checks = 0;
		reset_n = 1'b0;
		jitter_on = 1'b0;
		repeat (16) @(posedge clk);
		check("oe in reset", sda_oe_n, 1'b1);
		check("sda_o in reset", sda_o, 1'b1);
		check("por in reset", por_reset_n, 1'b0);
		check("busy in reset", write_busy, 1'b0);
		reset_n <= 1'b1;
		repeat (10) @(posedge clk);
		check("por early", por_reset_n, 1'b0);
		repeat (30) @(posedge clk);
		check("por done", por_reset_n, 1'b1);
		jitter_on = 1'b1;
		foreach (bad_sb[i]) begin
			m.start_c();
			m.wr_byte(bad_sb[i], 8, ack);
			check("foreign slave", ack, 1'b0);
			m.stop_c();
		end
		q = '{8'h5A};
		wr_frame(TA, 9'h010, 1'b0, 1'b1);
		rd_frame(TR, 9'h1FF, 1, 8'h61);
		q = '{8'h02};
		wr_frame(TR, 9'h1FF, 1'b1, 1'b0);
		rd_frame(TR, 9'h1FF, 1, 8'h63);
		rd_frame(TR, 9'h0FF, 1, 8'h00);
		q = '{8'hFF};
		wr_frame(TR, 9'h0FF, 1'b1, 1'b0);
		rd_frame(TR, 9'h0FF, 1, 8'hFF);
		q.delete();
		repeat (20) q.push_back(8'($random(seed)));
		wr_frame(TA, 9'h13A, 1'b1, 1'b1);
		q = '{8'h11, 8'h22};
		wr_frame(TA, 9'h1FE, 1'b1, 1'b1);
		q = '{8'h33};
		wr_frame(TA, 9'h000, 1'b1, 1'b1);
		head(TA, 9'h13B);
		m.wr_byte(8'hC3, 4, ack);
		m.stop_c();
		repeat (3) @(posedge clk);
		check("abandon busy", write_busy, 1'b0);
		head(TA, 9'h135);
		m.stop_c();
		ctr_m = 9'h135;
		cur_read();
		cur_read();
		rd_frame(TA, 9'h130, 16, 8'h00);
		rd_frame(TA, 9'h1FE, 3, 8'h00);
		q = '{8'h06};
		wr_frame(TR, 9'h1FF, 1'b1, 1'b0);
		q = '{8'h72};
		wr_frame(TR, 9'h1FF, 1'b1, 1'b1);
		rd_frame(TR, 9'h1FF, 1, 8'h72);
		q = '{8'hE7};
		wr_frame(TA, 9'h150, 1'b0, 1'b1);
		summarize();
	end
	// Watchdog beyond the planned traffic
	initial begin
		#380000;
		bad_count++;
		summarize();
	end
endmodule : tb
